// ===== core/drm_pkg.sv
// package for the descriptor ring manager: register map, descriptor layout, states
// assumes a 32-bit apb slave and a 32-bit descriptor memory port on one clock
// Functional notes
// - completed pointer holds address of the last fully finished descriptor.
// - engine next pointer holds address of the descriptor processed next.
// - host writes the software tail pointer; engine stops at it.
// - host and engine each touch only descriptors they currently own.
// - on finish, engine writes completion, first and last flags into descriptor.
// - packets may span one descriptor or several consecutive descriptors.
// - card-to-host direction reports the actual received byte count.
// - engine notifies host of completions, e.g. interrupt on flagged descriptors.
// - user control bits in transmit descriptors are forwarded with the data.
// - descriptors form a fixed circular ring, reused without allocation.
package drm_pkg;
  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_RING_START = 8'h04;
  localparam logic [7:0] REG_RING_END = 8'h08;
  localparam logic [7:0] REG_NEXT = 8'h0c;
  localparam logic [7:0] REG_TAIL = 8'h10;
  localparam logic [7:0] REG_COMPLETED = 8'h14;
  localparam logic [7:0] REG_IRQ_STATUS = 8'h18;
  localparam logic [7:0] REG_IRQ_MASK = 8'h1c;
  localparam logic [7:0] REG_STATE = 8'h20;
  // control register fields
  localparam int CTRL_ENABLE = 0;
  localparam int CTRL_DIR = 1;
  // interrupt status bits
  localparam int IRQ_W = 2;
  localparam int IRQ_DESC = 0;
  localparam int IRQ_PKT = 1;
  // descriptor words: control at +0, status at +4, stride 8 bytes
  localparam logic [31:0] DESC_STRIDE = 32'h0000_0008;
  localparam logic [31:0] DESC_STAT_OFS = 32'h0000_0004;
  // control word fields
  localparam int DC_FIRST = 0;
  localparam int DC_LAST = 1;
  localparam int DC_IRQ = 2;
  localparam int DC_USER_LO = 8;
  localparam int DC_LEN_LO = 16;
  // status word fields
  localparam int DS_DONE = 0;
  localparam int DS_FIRST = 1;
  localparam int DS_LAST = 2;
  localparam int DS_USER_LO = 8;
  localparam int DS_CNT_LO = 16;
  // reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [1:0] RST_CTRL = 2'h0;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_FETCH = 3'b001,
    ST_XFER = 3'b010,
    ST_STAT = 3'b011
  } drm_state_e;
endpackage

// ===== core/drm_irq.sv
// sticky interrupt status with mask and one level output
// assumes event pulses and write strobes from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module drm_irq #(
  parameter int W = 2
) (
  input wire logic clk_i, // system clock
  input wire logic rst_i, // async reset, high
  input wire logic [W-1:0] ev_i, // event pulses
  input wire logic clr_we_i, // status write strobe
  input wire logic mask_we_i, // mask write strobe
  input wire logic [W-1:0] wdata_i, // write data
  output logic [W-1:0] status_o, // sticky status
  output logic [W-1:0] mask_o, // enable mask
  output logic irq_o // level interrupt
);
  logic [W-1:0] status_r, status_nxt, mask_r, mask_nxt;
  logic irq_r, irq_nxt;

  // set beats clear so a same-cycle event is never lost
  always_comb begin
    status_nxt = status_r;
    mask_nxt = mask_r;
    if (clr_we_i) begin
      status_nxt = status_r & ~wdata_i;
    end
    status_nxt = status_nxt | ev_i;
    if (mask_we_i) begin
      mask_nxt = wdata_i;
    end
    irq_nxt = |(status_nxt & mask_nxt);
  end

  // registers only
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      status_r <= '0;
      mask_r <= '0;
      irq_r <= 1'b0;
    end else begin
      status_r <= status_nxt;
      mask_r <= mask_nxt;
      irq_r <= irq_nxt;
    end
  end

  assign status_o = status_r;
  assign mask_o = mask_r;
  assign irq_o = irq_r;
endmodule
`default_nettype wire

// ===== core/drm_engine.sv
// descriptor ring engine for one dma channel with apb registers
// assumes descriptor memory answers mem_ack_i one pulse per held request,
// and stream partners on the same clock
`timescale 1ns/1ps
`default_nettype none
module drm_engine #(
  parameter int LEN_W = 16,
  parameter int USER_W = 8
) (
  input wire logic clk_i, // system clock 20 mhz
  input wire logic rst_i, // async reset, high
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error, unmapped
  output logic mem_req_o, // descriptor access request
  output logic mem_we_o, // descriptor write
  output logic [31:0] mem_addr_o, // descriptor byte address
  output logic [31:0] mem_wdata_o, // descriptor write data
  input wire logic [31:0] mem_rdata_i, // descriptor read data
  input wire logic mem_ack_i, // access done pulse
  output logic tx_valid_o, // host-to-card fragment valid
  output logic tx_first_o, // fragment opens packet
  output logic tx_last_o, // fragment closes packet
  output logic [USER_W-1:0] tx_user_o, // forwarded user control
  output logic [LEN_W-1:0] tx_len_o, // fragment length in bytes
  input wire logic tx_ready_i, // data side took fragment
  input wire logic rx_valid_i, // card-to-host fragment valid
  input wire logic rx_first_i, // fragment opens packet
  input wire logic rx_last_i, // fragment closes packet
  input wire logic [USER_W-1:0] rx_user_i, // user status
  input wire logic [LEN_W-1:0] rx_len_i, // bytes actually received
  output logic rx_ready_o, // buffer available
  output logic irq_o // level interrupt
);
  localparam int PAD_W = 32 - LEN_W - USER_W - 8;

  drm_pkg::drm_state_e st_r, st_nxt;
  logic [1:0] ctrl_r, ctrl_nxt;
  logic [31:0] start_r, start_nxt, end_r, end_nxt;
  logic [31:0] next_r, next_nxt, tail_r, tail_nxt, done_r, done_nxt;
  logic [31:0] desc_r, desc_nxt, wrap_ptr;
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
  logic req_r, req_nxt, we_r, we_nxt;
  logic [31:0] addr_r, addr_nxt, wdata_r, wdata_nxt;
  logic txv_r, txv_nxt, txf_r, txf_nxt, txl_r, txl_nxt;
  logic [USER_W-1:0] txu_r, txu_nxt;
  logic [LEN_W-1:0] txn_r, txn_nxt;
  logic rxr_r, rxr_nxt;
  logic acc, wr, clr_we, mask_we, enable, dir_rx;
  logic [drm_pkg::IRQ_W-1:0] ev, irq_status, irq_mask;

  assign acc = psel & penable;
  assign wr = acc & pready_r & pwrite;
  assign enable = ctrl_r[drm_pkg::CTRL_ENABLE];
  assign dir_rx = ctrl_r[drm_pkg::CTRL_DIR];
  assign clr_we = wr && (paddr == drm_pkg::REG_IRQ_STATUS);
  assign mask_we = wr && (paddr == drm_pkg::REG_IRQ_MASK);

  assign wrap_ptr = (next_r == end_r) ? start_r : next_r + drm_pkg::DESC_STRIDE;

  // interrupt events fire when the status write of a descriptor lands
  // completion notify
  always_comb begin
    ev = '0;
    if (st_r == drm_pkg::ST_STAT && mem_ack_i) begin
      ev[drm_pkg::IRQ_DESC] = desc_r[drm_pkg::DC_IRQ];
      ev[drm_pkg::IRQ_PKT] = wdata_r[drm_pkg::DS_LAST];
    end
  end

  drm_irq #(
    .W(drm_pkg::IRQ_W)
  ) u_irq (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ev_i(ev),
    .clr_we_i(clr_we),
    .mask_we_i(mask_we),
    .wdata_i(pwdata[drm_pkg::IRQ_W-1:0]),
    .status_o(irq_status),
    .mask_o(irq_mask),
    .irq_o(irq_o)
  );

  // next values for bus slave, ring pointers and descriptor walker
  always_comb begin
    st_nxt = st_r;
    ctrl_nxt = ctrl_r;
    start_nxt = start_r;
    end_nxt = end_r;
    next_nxt = next_r;
    tail_nxt = tail_r;
    done_nxt = done_r;
    desc_nxt = desc_r;
    prdata_nxt = prdata_r;
    pslverr_nxt = pslverr_r;
    req_nxt = req_r;
    we_nxt = we_r;
    addr_nxt = addr_r;
    wdata_nxt = wdata_r;
    txv_nxt = txv_r;
    txf_nxt = txf_r;
    txl_nxt = txl_r;
    txu_nxt = txu_r;
    txn_nxt = txn_r;
    rxr_nxt = rxr_r;
    // one wait state: ready rises on the second access cycle
    pready_nxt = acc & ~pready_r;
    if (acc && !pready_r) begin
      prdata_nxt = drm_pkg::RST_WORD;
      pslverr_nxt = 1'b0;
      if (paddr == drm_pkg::REG_CTRL) begin
        prdata_nxt = {30'h0, ctrl_r};
      end else if (paddr == drm_pkg::REG_RING_START) begin
        prdata_nxt = start_r;
      end else if (paddr == drm_pkg::REG_RING_END) begin
        prdata_nxt = end_r;
      end else if (paddr == drm_pkg::REG_NEXT) begin
        prdata_nxt = next_r;
      end else if (paddr == drm_pkg::REG_TAIL) begin
        prdata_nxt = tail_r;
      end else if (paddr == drm_pkg::REG_COMPLETED) begin
        prdata_nxt = done_r;
      end else if (paddr == drm_pkg::REG_IRQ_STATUS) begin
        prdata_nxt = {30'h0, irq_status};
      end else if (paddr == drm_pkg::REG_IRQ_MASK) begin
        prdata_nxt = {30'h0, irq_mask};
      end else if (paddr == drm_pkg::REG_STATE) begin
        prdata_nxt = {29'h0, st_r};
      end else begin
        pslverr_nxt = 1'b1;
      end
    end
    // register writes; next and completed pointer writes only while enable is clear, and a completed write clears it to zero
    if (wr) begin
      if (paddr == drm_pkg::REG_CTRL) begin
        ctrl_nxt = pwdata[1:0];
      end else if (paddr == drm_pkg::REG_RING_START) begin
        start_nxt = pwdata;
      end else if (paddr == drm_pkg::REG_RING_END) begin
        end_nxt = pwdata;
      end else if (paddr == drm_pkg::REG_NEXT && !enable) begin
        next_nxt = pwdata;
      end else if (paddr == drm_pkg::REG_TAIL) begin
        tail_nxt = pwdata;
      end else if (paddr == drm_pkg::REG_COMPLETED && !enable) begin
        done_nxt = drm_pkg::RST_WORD;
      end
    end
    case (st_r)
      drm_pkg::ST_IDLE: begin
        if (enable && next_r != tail_r) begin
          req_nxt = 1'b1;
          we_nxt = 1'b0;
          addr_nxt = next_r;
          st_nxt = drm_pkg::ST_FETCH;
        end
      end
      drm_pkg::ST_FETCH: begin
        if (mem_ack_i) begin
          req_nxt = 1'b0;
          desc_nxt = mem_rdata_i;
          st_nxt = drm_pkg::ST_XFER;
          if (dir_rx) begin
            rxr_nxt = 1'b1;
          end else begin
            txv_nxt = 1'b1;
            txf_nxt = mem_rdata_i[drm_pkg::DC_FIRST];
            txl_nxt = mem_rdata_i[drm_pkg::DC_LAST];
            txu_nxt = mem_rdata_i[drm_pkg::DC_USER_LO +: USER_W];
            txn_nxt = mem_rdata_i[drm_pkg::DC_LEN_LO +: LEN_W];
          end
        end
      end
      drm_pkg::ST_XFER: begin
        if (!dir_rx && txv_r && tx_ready_i) begin
          txv_nxt = 1'b0;
          wdata_nxt = {txn_r, txu_r, {PAD_W{1'b0}}, 5'h0, txl_r, txf_r, 1'b1};
          req_nxt = 1'b1;
          we_nxt = 1'b1;
          addr_nxt = next_r + drm_pkg::DESC_STAT_OFS;
          st_nxt = drm_pkg::ST_STAT;
        end else if (dir_rx && rxr_r && rx_valid_i) begin
          rxr_nxt = 1'b0;
          wdata_nxt = {rx_len_i, rx_user_i, {PAD_W{1'b0}}, 5'h0, rx_last_i,
                       rx_first_i, 1'b1};
          req_nxt = 1'b1;
          we_nxt = 1'b1;
          addr_nxt = next_r + drm_pkg::DESC_STAT_OFS;
          st_nxt = drm_pkg::ST_STAT;
        end
      end
      drm_pkg::ST_STAT: begin
        if (mem_ack_i) begin
          req_nxt = 1'b0;
          we_nxt = 1'b0;
          done_nxt = next_r;
          next_nxt = wrap_ptr;
          st_nxt = drm_pkg::ST_IDLE;
        end
      end
      default: begin
        st_nxt = drm_pkg::ST_IDLE;
      end
    endcase
  end

  // registers only
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r <= drm_pkg::ST_IDLE;
      ctrl_r <= drm_pkg::RST_CTRL;
      start_r <= drm_pkg::RST_WORD;
      end_r <= drm_pkg::RST_WORD;
      next_r <= drm_pkg::RST_WORD;
      tail_r <= drm_pkg::RST_WORD;
      done_r <= drm_pkg::RST_WORD;
      desc_r <= drm_pkg::RST_WORD;
      prdata_r <= drm_pkg::RST_WORD;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      req_r <= 1'b0;
      we_r <= 1'b0;
      addr_r <= drm_pkg::RST_WORD;
      wdata_r <= drm_pkg::RST_WORD;
      txv_r <= 1'b0;
      txf_r <= 1'b0;
      txl_r <= 1'b0;
      txu_r <= '0;
      txn_r <= '0;
      rxr_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      ctrl_r <= ctrl_nxt;
      start_r <= start_nxt;
      end_r <= end_nxt;
      next_r <= next_nxt;
      tail_r <= tail_nxt;
      done_r <= done_nxt;
      desc_r <= desc_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      req_r <= req_nxt;
      we_r <= we_nxt;
      addr_r <= addr_nxt;
      wdata_r <= wdata_nxt;
      txv_r <= txv_nxt;
      txf_r <= txf_nxt;
      txl_r <= txl_nxt;
      txu_r <= txu_nxt;
      txn_r <= txn_nxt;
      rxr_r <= rxr_nxt;
    end
  end

  // outputs straight from flops
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign mem_req_o = req_r;
  assign mem_we_o = we_r;
  assign mem_addr_o = addr_r;
  assign mem_wdata_o = wdata_r;
  assign tx_valid_o = txv_r;
  assign tx_first_o = txf_r;
  assign tx_last_o = txl_r;
  assign tx_user_o = txu_r;
  assign tx_len_o = txn_r;
  assign rx_ready_o = rxr_r;
endmodule
`default_nettype wire

// ===== test/drm_engine_assertions.sv
// port checker for the descriptor ring engine
// assumes bind onto drm_engine, one clock, async high reset
`timescale 1ns/1ps
`default_nettype none
module drm_engine_assertions #(
  parameter int LEN_W = 16,
  parameter int USER_W = 8
) (
  input wire logic clk_i, // clock
  input wire logic rst_i, // reset
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pready, // apb ready
  input wire logic mem_req_o, // memory request
  input wire logic mem_we_o, // memory write
  input wire logic [31:0] mem_addr_o, // memory address
  input wire logic [31:0] mem_wdata_o, // memory write data
  input wire logic mem_ack_i, // memory ack
  input wire logic tx_valid_o, // tx valid
  input wire logic tx_ready_i, // tx ready
  input wire logic [USER_W-1:0] tx_user_o, // tx user
  input wire logic [LEN_W-1:0] tx_len_o, // tx length
  input wire logic rx_valid_i, // rx valid
  input wire logic rx_ready_o, // rx ready
  input wire logic rx_first_i, // rx first
  input wire logic rx_last_i, // rx last
  input wire logic [LEN_W-1:0] rx_len_i // rx length
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // status write back of a finished descriptor
  sequence s_stat_wr;
    mem_req_o && mem_we_o;
  endsequence
  a_apb_one_wait: assert property ($rose(penable) && psel |-> !pready ##1 pready)
    else $error("apb answer not after one wait state");
  a_req_hold: assert property (mem_req_o && !mem_ack_i |=>
    mem_req_o && $stable(mem_addr_o) && $stable(mem_we_o))
    else $error("memory request changed before ack");
  a_req_release: assert property (mem_ack_i |=> !mem_req_o)
    else $error("memory request kept after ack");
  a_stat_done: assert property (s_stat_wr |-> mem_wdata_o[0] && mem_addr_o[2:0] == 3'h4)
    else $error("status write lacks done bit or offset");
  a_tx_hold: assert property (tx_valid_o && !tx_ready_i |=>
    tx_valid_o && $stable(tx_len_o) && $stable(tx_user_o))
    else $error("tx fragment dropped or changed");
  a_tx_then_stat: assert property (tx_valid_o && tx_ready_i |=> !tx_valid_o ##0 s_stat_wr)
    else $error("no status write after tx fragment");
  a_rx_count: assert property (rx_valid_i && rx_ready_o |=>
    s_stat_wr ##0 mem_wdata_o[31:16] == $past(rx_len_i))
    else $error("rx byte count not written");
  a_rx_flags: assert property (rx_valid_i && rx_ready_o |=>
    mem_wdata_o[2:1] == {$past(rx_last_i), $past(rx_first_i)})
    else $error("rx fragment flags not written");
endmodule
`default_nettype wire

// ===== test/drm_mem_model.sv
// behavioural descriptor memory answering the engine
// assumes requests held until ack, byte addresses below 128
`timescale 1ns/1ps
`default_nettype none
module drm_mem_model (
  input wire logic clk_i, // clock
  input wire logic rst_i, // async reset, high
  input wire logic mem_req_i, // access request
  input wire logic mem_we_i, // write when high
  input wire logic [31:0] mem_addr_i, // byte address
  input wire logic [31:0] mem_wdata_i, // write data
  input wire logic [3:0] delay_i, // wait cycles before ack
  output logic [31:0] mem_rdata_o, // read data, valid with ack
  output logic mem_ack_o // one-cycle done pulse
);
  logic [31:0] mem [32];
  logic [3:0] wait_r;
  // touch only on request
  // data churns outside ack so a late sample cannot pass by luck
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      mem_ack_o <= 1'h0;
      wait_r <= 4'h0;
      mem_rdata_o <= 32'h0;
    end else begin
      mem_ack_o <= 1'h0;
      mem_rdata_o <= ~mem_rdata_o;
      if (mem_req_i && !mem_ack_o) begin
        if (wait_r >= delay_i) begin
          mem_ack_o <= 1'h1;
          wait_r <= 4'h0;
          if (mem_we_i) mem[mem_addr_i[6:2]] <= mem_wdata_i;
          else mem_rdata_o <= mem[mem_addr_i[6:2]];
        end else begin
          wait_r <= wait_r + 4'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== test/tb_dma_descriptor_ring_manager.sv
// self-checking bench for the descriptor ring engine
// assumes the memory model as host memory, apb master here
`timescale 1ns/1ps
`default_nettype none
module tb_dma_descriptor_ring_manager;
  typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic err;} drm_row_s;
  logic clk_i, rst_i, psel, penable, pwrite, pready, pslverr, tx_ready_i, rx_valid_i;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, mem_addr, mem_wdata, mem_rdata, q;
  logic mem_req, mem_we, mem_ack, tx_valid_o, tx_first_o, tx_last_o, rx_ready_o, irq_o;
  logic [7:0] tx_user_o;
  logic [15:0] tx_len_o;
  logic [3:0] dly;
  logic rx_first_i, rx_last_i;
  logic err;
  int error_cnt = 0;
  int compares = 0;
  // first, last, irq flags per descriptor
  logic [31:0] d [4] = '{32'h0040_5a01, 32'h0020_3306, 32'h0010_4407, 32'h0008_1103};
  drm_row_s rows [13] = '{'{1'h0, 8'h00, 32'h0, 1'h0}, '{1'h0, 8'h14, 32'h0, 1'h0},
    '{1'h0, 8'h18, 32'h0, 1'h0}, '{1'h1, 8'h04, 32'h0, 1'h0}, '{1'h1, 8'h08, 32'h18, 1'h0},
    '{1'h1, 8'h0c, 32'h0, 1'h0}, '{1'h1, 8'h10, 32'h0, 1'h0}, '{1'h1, 8'h1c, 32'h3, 1'h0},
    '{1'h0, 8'h1c, 32'h3, 1'h0}, '{1'h0, 8'h08, 32'h18, 1'h0}, '{1'h0, 8'h40, 32'h0, 1'h1},
    '{1'h1, 8'h44, 32'hffff, 1'h1}, '{1'h0, 8'h20, 32'h0, 1'h0}};
  drm_engine i_dut (.clk_i(clk_i), .rst_i(rst_i), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mem_req_o(mem_req), .mem_we_o(mem_we), .mem_addr_o(mem_addr),
    .mem_wdata_o(mem_wdata), .mem_rdata_i(mem_rdata), .mem_ack_i(mem_ack),
    .tx_valid_o(tx_valid_o), .tx_first_o(tx_first_o), .tx_last_o(tx_last_o),
    .tx_user_o(tx_user_o), .tx_len_o(tx_len_o), .tx_ready_i(tx_ready_i),
    .rx_valid_i(rx_valid_i), .rx_first_i(rx_first_i), .rx_last_i(rx_last_i), .rx_user_i(8'h7e),
    .rx_len_i(16'h002a), .rx_ready_o(rx_ready_o), .irq_o(irq_o));
  drm_mem_model i_mem (.clk_i(clk_i), .rst_i(rst_i), .mem_req_i(mem_req), .mem_we_i(mem_we),
    .mem_addr_i(mem_addr), .mem_wdata_i(mem_wdata), .delay_i(dly), .mem_rdata_o(mem_rdata),
    .mem_ack_o(mem_ack));
  // compare and count
  task chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // one apb transfer, held until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk_i);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_i);
    penable <= 1'h1;
    do @(posedge clk_i); while (pready !== 1'h1);
    q = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  // take one tx fragment after a stall and check its fields
  // always step one edge first: the fragment just taken still reads valid here
  task tx_take(input logic [31:0] c);
    do @(posedge clk_i); while (tx_valid_o !== 1'h1);
    chk({tx_first_o, tx_last_o}, {c[0], c[1]});
    chk({tx_len_o, tx_user_o}, c[31:8]);
    repeat (3) @(posedge clk_i);
    tx_ready_i <= 1'h1;
    @(posedge clk_i);
    tx_ready_i <= 1'h0;
  endtask
  // poll the next pointer until it reaches the target
  task wait_next(input logic [31:0] t);
    for (int i = 0; i < 60 && q !== t; i++) apb(1'h0, 8'h0c, 32'h0);
    chk(q, t);
  endtask
  task complete_run;
    $display("mismatches %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // clock, 50 ns period
  initial begin
    clk_i = 1'h0;
    forever #25 clk_i = ~clk_i;
  end
  // hang guard
  initial begin
    repeat (20000) @(posedge clk_i);
    error_cnt++;
    complete_run;
  end
  initial begin
    {rst_i, psel, penable, pwrite, tx_ready_i, rx_valid_i} = 6'h20;
    {rx_first_i, rx_last_i} = 2'h2;
    {paddr, pwdata, dly, q} = '0;
    // one four-entry ring for this channel
    for (int i = 0; i < 4; i++) i_mem.mem[2 * i] = d[i];
    repeat (6) @(posedge clk_i);
    rst_i <= 1'h0;
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) chk(q, rows[i].d);
      chk(err, rows[i].err);
    end
    apb(1'h1, 8'h00, 32'h1);
    apb(1'h1, 8'h10, 32'h18);
    for (int i = 0; i < 3; i++) tx_take(d[i]);
    wait_next(32'h18);
    for (int i = 0; i < 3; i++) chk(i_mem.mem[2 * i + 1], {d[i][31:8], 5'h0, d[i][1:0], 1'h1});
    apb(1'h0, 8'h14, 32'h0);
    chk(q, 32'h10);
    chk(irq_o, 1'h1);
    apb(1'h0, 8'h18, 32'h0);
    chk(q, 32'h3);
    apb(1'h1, 8'h1c, 32'h0);
    repeat (2) @(posedge clk_i);
    chk(irq_o, 1'h0);
    apb(1'h1, 8'h18, 32'h3);
    apb(1'h1, 8'h1c, 32'h3);
    apb(1'h0, 8'h18, 32'h0);
    chk(q, 32'h0);
    chk(tx_valid_o, 1'h0);
    // slow memory, submit across the ring end
    dly <= 4'h3;
    apb(1'h1, 8'h10, 32'h8);
    tx_take(d[3]);
    tx_take(d[0]);
    wait_next(32'h8);
    apb(1'h0, 8'h14, 32'h0);
    chk(q, 32'h0);
    apb(1'h0, 8'h18, 32'h0);
    chk(q, 32'h2);
    apb(1'h1, 8'h0c, 32'h10);
    apb(1'h0, 8'h0c, 32'h0);
    chk(q, 32'h8);
    // rx setup, tail at ring end
    apb(1'h1, 8'h00, 32'h0);
    apb(1'h1, 8'h0c, 32'h0);
    apb(1'h1, 8'h14, 32'h0);
    apb(1'h1, 8'h10, 32'h18);
    apb(1'h1, 8'h00, 32'h3);
    rx_valid_i <= 1'h1;
    do @(posedge clk_i); while (rx_ready_o !== 1'h1);
    rx_valid_i <= 1'h0;
    q = 32'h0;
    wait_next(32'h8);
    chk(i_mem.mem[1], 32'h002a_7e03);
    // mid-run reset drops the pending rx buffer and clears the pointers
    rst_i <= 1'h1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'h0;
    chk(rx_ready_o, 1'h0);
    chk(irq_o, 1'h0);
    apb(1'h0, 8'h0c, 32'h0);
    chk(q, 32'h0);
    apb(1'h0, 8'h00, 32'h0);
    chk(q, 32'h0);
    complete_run;
  end
endmodule
bind drm_engine drm_engine_assertions #(.LEN_W(LEN_W), .USER_W(USER_W)) i_chk (
  .clk_i(clk_i), .rst_i(rst_i), .psel(psel), .penable(penable), .pready(pready),
  .mem_req_o(mem_req_o), .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o),
  .mem_wdata_o(mem_wdata_o), .mem_ack_i(mem_ack_i), .tx_valid_o(tx_valid_o),
  .tx_ready_i(tx_ready_i), .tx_user_o(tx_user_o), .tx_len_o(tx_len_o),
  .rx_valid_i(rx_valid_i), .rx_ready_o(rx_ready_o), .rx_first_i(rx_first_i),
  .rx_last_i(rx_last_i), .rx_len_i(rx_len_i));
`default_nettype wire
